// ===== hw/dsw_pkg.sv
// package: word layout, range codes and timing constants of the dac serial write port
package dsw_pkg;
   localparam int          WORD_BITS     = 24;
   localparam int          CNT_W         = 5;
   localparam logic [4:0]  WORD_CNT      = 5'h18;
   localparam int          FIXED_ZERO_POS = 20;
   localparam int          ADDR_MSB      = 19;
   localparam int          ADDR_LSB      = 16;
   localparam int          DATA_MSB      = 15;
   localparam int          SEG_BITS      = 6;
   localparam int          SEG_COUNT     = 63;
   localparam int          LADDER_BITS   = 10;
   localparam int          RANGE_BITS    = 3;
   localparam int          CODING_POS    = 3;
   localparam logic [3:0]  ADDR_CONTROL  = 4'h4;
   localparam logic [3:0]  ADDR_DAC_LOAD = 4'h3;
   localparam logic [2:0]  RANGE_RESET   = 3'h0;
   localparam logic [15:0] CODE_RESET    = 16'h0000;
   localparam logic [23:0] WORD_RESET    = 24'h000000;
   // ranges 0..3 bipolar in this block's mapping; 4..7 unipolar
   localparam logic [7:0]  RANGE_BIPOLAR = 8'h0f;
   localparam real         SCLK_PERIOD_NS = 80.0;
   localparam real         CLK_PERIOD_NS  = 10.0;
   localparam int          HALF_SCLK_CYC  = int'(SCLK_PERIOD_NS / CLK_PERIOD_NS) / 2;
   localparam int          DIV_W          = 8;
endpackage

// ===== hw/dsw_link_if.sv
// interface: four-wire serial link between host and dac port
`timescale 1ns/1ps
interface dsw_link_if;
   logic frame_n;
   logic sclk;
   logic serial_data_in;
   logic serial_data_out;
   logic serial_data_out_oe_n;
   logic sdo_wire;
   assign sdo_wire = serial_data_out_oe_n ? 1'b1 : serial_data_out;
   modport host (output frame_n, output sclk, output serial_data_in, input sdo_wire);
   modport dev  (input frame_n, input sclk, input serial_data_in,
                 output serial_data_out, output serial_data_out_oe_n);
endinterface

// ===== hw/dsw_code_path.sv
// module: coding conversion and segment/ladder switch split of the dac code
`timescale 1ns/1ps
module dsw_code_path #(
   parameter int DATA_BITS = 16
) (
   input  wire logic                 clk_i,
   input  wire logic                 rst_n_i,
   input  wire logic [15:0]          code_i,
   input  wire logic                 twos_i,
   input  wire logic [2:0]           range_i,
   output logic [62:0]               segment_switches_o,
   output logic [9:0]                ladder_switches_o
);
   logic [15:0] bin;
   logic        bip;
   initial begin
      if (DATA_BITS != 16 && DATA_BITS != 12) $error("DATA_BITS must be 16 or 12");
   end
   always_comb begin
      bip = dsw_pkg::RANGE_BIPOLAR[range_i];
      // twos complement only honoured on bipolar ranges
      bin = (twos_i && bip) ? (code_i ^ 16'h8000) : code_i;
      if (DATA_BITS == 12) begin
         bin = {bin[15:4], 4'h0};
      end
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         segment_switches_o <= '0;
         ladder_switches_o  <= '0;
      end else begin
         for (int i = 0; i < dsw_pkg::SEG_COUNT; i++) begin
            segment_switches_o[i] <= (32'(bin[15:10]) > i);
         end
         ladder_switches_o <= bin[9:0];
      end
   end
endmodule

// ===== hw/dsw_host.sv
// module: host end, divides clk into the serial clock and shifts one 24-bit word
`timescale 1ns/1ps
module dsw_host #(
   parameter int HALF_CYC = dsw_pkg::HALF_SCLK_CYC
) (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        start_i,
   input  wire logic [23:0] word_i,
   output logic             busy_o,
   output logic             done_o,
   dsw_link_if.host         link
);
   initial begin
      if (HALF_CYC < 1 || HALF_CYC > 255) $error("HALF_CYC out of range");
   end
   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_SHIFT = 2'b01,
      H_END = 2'b10
   } dsw_hstate_type;
   dsw_hstate_type  st_q;
   logic [7:0]      div_q;
   logic            tick;
   logic [23:0]     sh_q;
   logic [4:0]      edges_q;
   logic            frame_n_q;
   logic            sclk_q;

   assign tick = (div_q == 8'(HALF_CYC - 1));
   assign link.frame_n        = frame_n_q;
   assign link.sclk           = sclk_q;
   assign link.serial_data_in = sh_q[23];

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) div_q <= '0;
      else if (st_q == H_IDLE || tick) div_q <= '0;
      else div_q <= div_q + 8'h01;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q      <= H_IDLE;
         frame_n_q <= 1'b1;
         sclk_q    <= 1'b1;
         sh_q      <= dsw_pkg::WORD_RESET;
         edges_q   <= '0;
         busy_o    <= 1'b0;
         done_o    <= 1'b0;
      end else begin
         done_o <= 1'b0;
         unique case (st_q)
            H_IDLE: begin
               if (start_i) begin
                  // bit 20 forced to zero in every word sent
                  sh_q <= word_i & ~(24'h000001 << dsw_pkg::FIXED_ZERO_POS);
                  frame_n_q <= 1'b0;
                  edges_q <= '0;
                  busy_o <= 1'b1;
                  st_q <= H_SHIFT;
               end
            end
            H_SHIFT: if (tick) begin
               sclk_q <= ~sclk_q;
               if (sclk_q) begin
                  edges_q <= edges_q + 5'h01;
               end else if (edges_q == dsw_pkg::WORD_CNT) begin
                  st_q <= H_END;
               end else if (edges_q != 5'h00) begin
                  sh_q <= {sh_q[22:0], 1'b0};
               end
            end
            H_END: if (tick) begin
               frame_n_q <= 1'b1;
               busy_o <= 1'b0;
               done_o <= 1'b1;
               st_q <= H_IDLE;
            end
            default: st_q <= H_IDLE;
         endcase
      end
   end
endmodule

// ===== hw/dsw_device.sv
// module: device end, samples the link, validates and decodes each 24-bit word
`timescale 1ns/1ps
module dsw_device #(
   parameter int DATA_BITS = 16
) (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   dsw_link_if.dev          link,
   output logic             word_valid_o,
   output logic             word_error_o,
   output logic [3:0]       addr_o,
   output logic [15:0]      dac_code_o,
   output logic [2:0]       range_select_o,
   output logic             twos_coding_o,
   output logic [62:0]      segment_switches_o,
   output logic [9:0]       ladder_switches_o
);
   initial begin
      if (DATA_BITS != 16 && DATA_BITS != 12) $error("DATA_BITS must be 16 or 12");
   end

   // ***************************************************************
   // pin synchronisers and edge detection
   // ***************************************************************
   logic [1:0]  fr_s_q;
   logic [1:0]  ck_s_q;
   logic [1:0]  di_s_q;
   logic        fr_d_q;
   logic        ck_d_q;
   logic        fall;
   logic        rise;
   logic        frame_rise;
   logic        frame_low;

   // frame select idles high, so its stages reset high: no false frame after reset
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fr_s_q <= 2'b11;
      end else begin
         fr_s_q <= {fr_s_q[0], link.frame_n};
      end
   end

   // serial clock idles high too, so no false falling edge after reset
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ck_s_q <= 2'b11;
      end else begin
         ck_s_q <= {ck_s_q[0], link.sclk};
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         di_s_q <= 2'b00;
      end else begin
         di_s_q <= {di_s_q[0], link.serial_data_in};
      end
   end

   // delayed copies of the settled levels for edge detection
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fr_d_q <= 1'b1;
         ck_d_q <= 1'b1;
      end else begin
         fr_d_q <= fr_s_q[1];
         ck_d_q <= ck_s_q[1];
      end
   end

   assign frame_low  = ~fr_s_q[1];
   // edges found from levels only, so a stopped clock is harmless
   assign fall       = ck_d_q & ~ck_s_q[1] & frame_low;
   assign rise       = ~ck_d_q & ck_s_q[1];
   assign frame_rise = ~fr_d_q & fr_s_q[1];

   // ***************************************************************
   // input shift register and edge counter
   // ***************************************************************
   logic [23:0] sh_q;
   logic [4:0]  cnt_q;
   logic        over_q;
   logic        sdo_q;
   logic        sdo_oe_n_q;

   // bits enter at the bottom, so the first bit sent ends up on top
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sh_q <= dsw_pkg::WORD_RESET;
      end else if (fall) begin
         sh_q <= {sh_q[22:0], di_s_q[1]};
      end
   end

   // counter stops at one word; a further fall raises the overrun flag and still shifts sh_q
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_q <= '0;
      end else if (!frame_low) begin
         cnt_q <= '0;
      end else if (fall && cnt_q != dsw_pkg::WORD_CNT) begin
         cnt_q <= cnt_q + 5'h01;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         over_q <= 1'b0;
      end else if (!frame_low) begin
         over_q <= 1'b0;
      end else if (fall && cnt_q == dsw_pkg::WORD_CNT) begin
         over_q <= 1'b1;
      end
   end

   // ***************************************************************
   // serial data out for readback and chaining
   // ***************************************************************
   // launched on the rise, so the bit is settled by the next fall
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sdo_q <= 1'b0;
      end else if (rise) begin
         sdo_q <= sh_q[23];
      end
   end

   // released while frame is high so other devices may share the line
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sdo_oe_n_q <= 1'b1;
      end else begin
         sdo_oe_n_q <= ~frame_low;
      end
   end

   assign link.serial_data_out      = sdo_q;
   assign link.serial_data_out_oe_n = sdo_oe_n_q;

   // ***************************************************************
   // decode on frame rise
   // ***************************************************************
   logic [3:0]  rx_addr;
   logic        good;
   logic        take;
   assign rx_addr = sh_q[dsw_pkg::ADDR_MSB:dsw_pkg::ADDR_LSB];
   assign good    = (cnt_q == dsw_pkg::WORD_CNT) && !over_q
                    && !sh_q[dsw_pkg::FIXED_ZERO_POS];
   assign take    = frame_rise & good;

   // one-cycle pulses that report every frame end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         word_valid_o <= 1'b0;
         word_error_o <= 1'b0;
      end else begin
         word_valid_o <= take;
         word_error_o <= frame_rise & ~good;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         addr_o <= '0;
      end else if (take) begin
         addr_o <= rx_addr;
      end
   end

   // control fields kept only from a good control word
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         range_select_o <= dsw_pkg::RANGE_RESET;
         twos_coding_o  <= 1'b0;
      end else if (take && rx_addr == dsw_pkg::ADDR_CONTROL) begin
         range_select_o <= sh_q[dsw_pkg::RANGE_BITS-1:0];
         twos_coding_o  <= sh_q[dsw_pkg::CODING_POS];
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dac_code_o <= dsw_pkg::CODE_RESET;
      end else if (take && rx_addr == dsw_pkg::ADDR_DAC_LOAD) begin
         dac_code_o <= sh_q[dsw_pkg::DATA_MSB:0];
      end
   end

   dsw_code_path #(.DATA_BITS(DATA_BITS)) u_path (
      .clk_i              (clk_i),
      .rst_n_i            (rst_n_i),
      .code_i             (dac_code_o),
      .twos_i             (twos_coding_o),
      .range_i            (range_select_o),
      .segment_switches_o (segment_switches_o),
      .ladder_switches_o  (ladder_switches_o)
   );
endmodule

// ===== bench/dsw_link_checker.sv
// checker: timing and framing of the link between host and device ends
`timescale 1ns/1ps
module dsw_link_checker (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic frame_n,
   input wire logic sclk,
   input wire logic serial_data_in,
   input wire logic serial_data_out_oe_n
);
   logic       sclk_q;
   logic [4:0] falls_q;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) sclk_q <= 1'b1;
      else sclk_q <= sclk;
   end
   // falls seen inside the frame, cleared while frame is high
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) falls_q <= 5'h00;
      else if (frame_n) falls_q <= 5'h00;
      else if (sclk_q && !sclk) falls_q <= falls_q + 5'h01;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   a_idle_clk_high: assert property (frame_n |-> sclk)
      else $error("sclk low outside frame");
   a_word_fall_count: assert property ($rose(frame_n) |-> falls_q == dsw_pkg::WORD_CNT)
      else $error("fall count at frame end");
   a_no_extra_fall: assert property (!frame_n && falls_q == dsw_pkg::WORD_CNT |-> !$fell(sclk))
      else $error("fall after the last bit");
   a_frame_after_pulse: assert property ($rose(frame_n) |-> $past(sclk, 3))
      else $error("frame raised too soon");
   a_frame_held_low: assert property ($fell(frame_n) |-> !frame_n [*8])
      else $error("frame released early");
   a_data_stable_fall: assert property ($fell(sclk) |-> $stable(serial_data_in))
      else $error("data moved at clock fall");
   a_half_period: assert property ($fell(sclk) |-> ##4 $rose(sclk))
      else $error("sclk low time wrong");
   a_sdo_released: assert property (frame_n [*4] |-> serial_data_out_oe_n)
      else $error("sdo driven while idle");
endmodule

// ===== bench/test_dac_serial_write_port.sv
// testbench: both ends over one link, a rule-breaking driver on a second link
`timescale 1ns/1ps
module test_dac_serial_write_port;
   logic        clk_i   = 1'b0;
   logic        rst_n_i = 1'b0;
   logic        start_i = 1'b0;
   logic [23:0] word_i  = 24'h000000;
   logic        busy_o, done_o, val_a, err_a, val_b, err_b, twos_a;
   logic [3:0]  addr_a;
   logic [15:0] code_a, code_b;
   logic [2:0]  rng_a;
   logic [62:0] seg_a;
   logic [9:0]  lad_a;
   int          bad_count = 0;
   int          cmp_count = 0;
   int          nva = 0, nea = 0, nvb = 0, neb = 0;
   logic        sdo_seen;
   dsw_link_if lk ();
   dsw_link_if lk2 ();
   always #5 clk_i = ~clk_i;
   initial begin
      lk2.frame_n = 1'b1;
      lk2.sclk = 1'b1;
      lk2.serial_data_in = 1'b0;
   end
   dsw_host i_dsw_host (.clk_i(clk_i), .rst_n_i(rst_n_i), .start_i(start_i), .word_i(word_i),
      .busy_o(busy_o), .done_o(done_o), .link(lk.host));
   dsw_device i_dsw_device (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(lk.dev),
      .word_valid_o(val_a), .word_error_o(err_a), .addr_o(addr_a), .dac_code_o(code_a),
      .range_select_o(rng_a), .twos_coding_o(twos_a), .segment_switches_o(seg_a),
      .ladder_switches_o(lad_a));
   dsw_device i_dsw_device_b (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(lk2.dev),
      .word_valid_o(val_b), .word_error_o(err_b), .addr_o(), .dac_code_o(code_b),
      .range_select_o(), .twos_coding_o(), .segment_switches_o(), .ladder_switches_o());
   dsw_link_checker i_dsw_link_checker (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .frame_n(lk.frame_n), .sclk(lk.sclk), .serial_data_in(lk.serial_data_in),
      .serial_data_out_oe_n(lk.serial_data_out_oe_n));
   // valid and error are one-cycle pulses, so count them as they come
   always @(posedge clk_i) begin
      nva += (val_a === 1'b1);
      nea += (err_a === 1'b1);
      nvb += (val_b === 1'b1);
      neb += (err_b === 1'b1);
   end
   task automatic chk(input string nm, input logic [62:0] exp, input logic [62:0] got);
      cmp_count++;
      if (exp !== got) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic send(input logic [23:0] w);
      int n;
      n = 0;
      @(posedge clk_i);
      start_i <= 1'b1;
      word_i  <= w;
      @(posedge clk_i);
      start_i <= 1'b0;
      @(negedge clk_i);
      chk("busy", 63'(1), 63'(busy_o));
      chk("frame low", 63'(0), 63'(lk.frame_n));
      do begin
         @(negedge clk_i);
         n++;
      end while (done_o !== 1'b1 && n < 400);
      if (n >= 400) bad_count++;
      chk("busy end", 63'(0), 63'(busy_o));
      repeat (8) @(posedge clk_i);
   endtask
   // nf falls; gap stalls the clock mid-word to make a burst clock
   task automatic drv(input logic [23:0] w, input int nf, input bit gap);
      @(posedge clk_i);
      lk2.frame_n <= 1'b0;
      for (int i = 0; i < nf; i++) begin
         lk2.serial_data_in <= (i < 24) ? w[23 - i] : 1'b0;
         repeat (4) @(posedge clk_i);
         lk2.sclk <= 1'b0;
         repeat (4) @(posedge clk_i);
         lk2.sclk <= 1'b1;
         if (gap && i == 11) repeat (40) @(posedge clk_i);
      end
      repeat (4) @(posedge clk_i);
      sdo_seen = lk2.sdo_wire;
      lk2.frame_n <= 1'b1;
      repeat (10) @(posedge clk_i);
   endtask
   task automatic t_ranges();
      int v;
      for (int r = 0; r < 8; r++) begin
         v = nva;
         send({3'h7, 1'b0, dsw_pkg::ADDR_CONTROL, 12'h000, dsw_pkg::RANGE_BIPOLAR[r], r[2:0]});
         chk("valid", 63'(v + 1), 63'(nva));
         chk("range", 63'(r[2:0]), 63'(rng_a));
         chk("twos", 63'(dsw_pkg::RANGE_BIPOLAR[r]), 63'(twos_a));
      end
      send({3'h0, 1'b0, dsw_pkg::ADDR_CONTROL, 12'h000, 1'b0, 3'h4});
      $display("test ranges done");
   endtask
   task automatic t_codes();
      int          v;
      logic [15:0] c;
      logic [15:0] tbl [5] = '{16'hffff, 16'h0000, 16'h8421, 16'h03ff, 16'h0400};
      for (int k = 0; k < 5; k++) begin
         c = tbl[k];
         send({3'h5, 1'b0, dsw_pkg::ADDR_DAC_LOAD, c});
         chk("code", 63'(c), 63'(code_a));
         chk("addr", 63'(dsw_pkg::ADDR_DAC_LOAD), 63'(addr_a));
         chk("segments", (63'h1 << c[15:10]) - 63'h1, seg_a);
         chk("ladder", 63'(c[9:0]), 63'(lad_a));
      end
      // the host end forces bit 20 low, so this word must still load
      v = nva;
      send({3'h0, 1'b1, dsw_pkg::ADDR_DAC_LOAD, 16'h1234});
      chk("valid bit20", 63'(v + 1), 63'(nva));
      chk("code bit20", 63'h1234, 63'(code_a));
      chk("error a", 63'(0), 63'(nea));
      send({3'h0, 1'b0, dsw_pkg::ADDR_CONTROL, 12'h000, 1'b1, 3'h0});
      send({3'h0, 1'b0, dsw_pkg::ADDR_DAC_LOAD, 16'h0000});
      chk("segments twos", 63'hffffffff, seg_a);
      send({3'h0, 1'b0, dsw_pkg::ADDR_CONTROL, 12'h000, 1'b1, 3'h4});
      chk("segments unipolar", 63'h0, seg_a);
      $display("test codes done");
   endtask
   task automatic t_link_b();
      repeat (3) begin
         @(posedge clk_i);
         lk2.sclk <= 1'b0;
         repeat (4) @(posedge clk_i);
         lk2.sclk <= 1'b1;
      end
      drv({3'h4, 1'b0, dsw_pkg::ADDR_DAC_LOAD, 16'habcd}, 24, 1'b1);
      chk("valid b", 63'(1), 63'(nvb));
      chk("sdo chain", 63'(1), 63'(sdo_seen));
      chk("code b", 63'habcd, 63'(code_b));
      drv({3'h0, 1'b0, dsw_pkg::ADDR_DAC_LOAD, 16'h5555}, 23, 1'b0);
      chk("short", 63'(1), 63'(neb));
      drv({3'h0, 1'b0, dsw_pkg::ADDR_DAC_LOAD, 16'h5555}, 25, 1'b0);
      chk("long", 63'(2), 63'(neb));
      drv({3'h0, 1'b1, dsw_pkg::ADDR_DAC_LOAD, 16'h1234}, 24, 1'b0);
      chk("bit20 b", 63'(3), 63'(neb));
      chk("sdo chain 0", 63'(0), 63'(sdo_seen));
      chk("sdo idle", 63'(1), 63'(lk2.sdo_wire));
      chk("code b kept", 63'habcd, 63'(code_b));
      $display("test link b done");
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk_i);
      bad_count++;
      end_of_test();
   end
   initial begin
      repeat (4) @(posedge clk_i);
      rst_n_i <= 1'b1;
      t_ranges();
      t_codes();
      t_link_b();
      end_of_test();
   end
endmodule
